/* File: rtl/csi_status_lamps.v */
`timescale 1ns/100ps
`include "csi_consts.vh"
// What this block does
// - Run lamp blinks normally, steady on failure
// - Link lamp on while network send correct
// - Fault lamp lit only when module faulty
// - Pulse lamp flashes while channel pulses arrive
// - Function lamp follows function input level
// - Eight channels, each with two lamps
// - Detect pulses from 10 to 100 kHz
module csi_status_lamps #(
  parameter RUN_HALF_CYC = `CSI_RUN_HALF_CYC,
  parameter STRETCH_CYC = `CSI_STRETCH_CYC
)
(
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_module_fail,
  input wire i_net_tx_ok,
  input wire [`CSI_NUM_CHAN-1:0] i_chan_pulse,
  input wire [`CSI_NUM_CHAN-1:0] i_chan_function_input,
  output reg o_run_lamp,
  output reg o_link_lamp,
  output reg o_fault_lamp,
  output wire [`CSI_NUM_CHAN-1:0] o_chan_pulse_lamp,
  output reg [`CSI_NUM_CHAN-1:0] o_chan_function_lamp
);


  // ****************************************
  // Timing overview
  // ****************************************
  // Level lamps follow their inputs three enabled edges later: two
  // synchroniser stages and the lamp flip-flop. A pulse lamp starts its
  // flash on the third enabled edge after a rising input.
  // With i_ce low and i_rst low every register holds, so the lamps freeze as they are.
  // Both counts may be shrunk for short runs, but neither may be zero,
  // since the wrap compare would then wait for the all-ones count.

  // ****************************************
  // Storage
  // ****************************************
  // Two stages per asynchronous input; only the second stage is read
  reg [`CSI_NUM_CHAN-1:0] pulse_s1_reg;
  reg [`CSI_NUM_CHAN-1:0] pulse_s2_reg;
  reg [`CSI_NUM_CHAN-1:0] func_s1_reg;
  reg [`CSI_NUM_CHAN-1:0] func_s2_reg;
  // Health flags: bit 1 module failed, bit 0 network send good
  reg [1:0] stat_s1_reg;
  reg [1:0] stat_s2_reg;
  // Blink timebase for the run lamp
  reg [`CSI_CNT_W-1:0] run_cnt_reg;
  reg [`CSI_CNT_W-1:0] run_cnt_next;
  reg blink_reg;
  reg blink_next;
  wire run_wrap;
  // Next values of the lamp flip-flops
  reg run_lamp_next;
  reg link_lamp_next;
  reg fault_lamp_next;
  reg [`CSI_NUM_CHAN-1:0] func_lamp_next;

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Run lamp level: a failure overrides the blink with steady light
  function run_level;
    input failed;
    input blink;
    begin
      run_level = failed | blink;
    end
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Field pulse pins; a pulse shorter than one clock may be lost here
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      pulse_s1_reg <= {`CSI_NUM_CHAN{1'b0}};
      pulse_s2_reg <= {`CSI_NUM_CHAN{1'b0}};
    end
    else if (i_ce)
    begin
      pulse_s1_reg <= i_chan_pulse;
      pulse_s2_reg <= pulse_s1_reg;
    end
  end

  // Function input pins, one stage pair per channel
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      func_s1_reg <= {`CSI_NUM_CHAN{1'b0}};
      func_s2_reg <= {`CSI_NUM_CHAN{1'b0}};
    end
    else if (i_ce)
    begin
      func_s1_reg <= i_chan_function_input;
      func_s2_reg <= func_s1_reg;
    end
  end

  // Health flags come from other logic on its own timing; treat as async
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      stat_s1_reg <= 2'h0;
      stat_s2_reg <= 2'h0;
    end
    else if (i_ce)
    begin
      stat_s1_reg <= {i_module_fail, i_net_tx_ok};
      stat_s2_reg <= stat_s1_reg;
    end
  end

  // ****************************************
  // Run lamp timebase
  // ****************************************
  // Half period end; the count wraps so the blink stays symmetric
  assign run_wrap = (run_cnt_reg == RUN_HALF_CYC - 27'd1);

  // Next count and blink phase
  always @*
  begin
    run_cnt_next = run_cnt_reg + 27'd1;
    blink_next = blink_reg;
    if (run_wrap)
    begin
      run_cnt_next = {`CSI_CNT_W{1'b0}};
      blink_next = ~blink_reg;
    end
  end

  // Runs on during a failure, so the blink resumes at an even rate
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      run_cnt_reg <= {`CSI_CNT_W{1'b0}};
      blink_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      run_cnt_reg <= run_cnt_next;
      blink_reg <= blink_next;
    end
  end

  // ****************************************
  // Module and function lamps
  // ****************************************
  // Lamp levels from the synchronised flags
  always @*
  begin
    run_lamp_next = run_level(stat_s2_reg[1], blink_reg);
    link_lamp_next = stat_s2_reg[0];
    fault_lamp_next = stat_s2_reg[1];
    func_lamp_next = func_s2_reg;
  end

  // Run lamp, registered so the pin comes straight from a flip-flop
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_run_lamp <= 1'b0;
    else if (i_ce)
      o_run_lamp <= run_lamp_next;
  end

  // Link lamp follows the network send health flag
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_link_lamp <= 1'b0;
    else if (i_ce)
      o_link_lamp <= link_lamp_next;
  end

  // Fault lamp shares the failure flag with the run lamp
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_fault_lamp <= 1'b0;
    else if (i_ce)
      o_fault_lamp <= fault_lamp_next;
  end

  // Function lamps mirror the input levels, no stretching
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_chan_function_lamp <= {`CSI_NUM_CHAN{1'b0}};
    else if (i_ce)
      o_chan_function_lamp <= func_lamp_next;
  end

  // ****************************************
  // Per-channel pulse lamps
  // ****************************************
  // One stretcher per channel keeps the channels independent
  genvar g;
  generate
    for (g = 0; g < `CSI_NUM_CHAN; g = g + 1)
    begin : g_chan
      csi_pulse_lamp #(
        .STRETCH_CYC(STRETCH_CYC)
      ) u_lamp (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pulse_sync(pulse_s2_reg[g]),
        .o_lamp(o_chan_pulse_lamp[g])
      );
    end
  endgenerate

endmodule

/* File: rtl/csi_consts.vh */
`ifndef CSI_CONSTS_VH
`define CSI_CONSTS_VH
// ****************************************
// Channel count and timing
// ****************************************
`define CSI_NUM_CHAN 8
// Clock period in picoseconds (250 MHz)
`define CSI_CLK_PS 4000
// Run lamp half period in microseconds
`define CSI_RUN_HALF_US 250000
// Pulse lamp stretch time in microseconds (on time per flash)
`define CSI_STRETCH_US 50000
// Slowest supported pulse rate gives the longest gap, in ns (10 kHz)
`define CSI_MAX_GAP_NS 100000
// Counter width for long counts
`define CSI_CNT_W 27
// Run lamp half period in clock cycles (250 ms at 250 MHz)
`define CSI_RUN_HALF_CYC 27'd62500000
// Pulse lamp on time, and dark time after it, in clock cycles (50 ms)
`define CSI_STRETCH_CYC 27'd12500000
`endif

/* File: rtl/csi_pulse_lamp.v */
`timescale 1ns/100ps
`include "csi_consts.vh"
// Per-channel pulse lamp: edge detect then stretched flash.
module csi_pulse_lamp #(
  parameter STRETCH_CYC = `CSI_STRETCH_CYC
)
(
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_pulse_sync,
  output reg o_lamp
);

  reg prev_reg;
  reg [`CSI_CNT_W-1:0] cnt_reg;
  reg busy_reg;

  // ****************************************
  // Edge detect and flash timing
  // ****************************************
  // Each rising edge starts one on/off flash cycle; edges during a flash are
  // absorbed, so at 100 kHz the lamp blinks at a steady visible rate.
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      prev_reg <= 1'b0;
      cnt_reg <= {`CSI_CNT_W{1'b0}};
      busy_reg <= 1'b0;
      o_lamp <= 1'b0;
    end
    else if (i_ce)
    begin
      prev_reg <= i_pulse_sync;
      if (busy_reg)
      begin
        if (cnt_reg == STRETCH_CYC - 27'd1)
        begin
          cnt_reg <= {`CSI_CNT_W{1'b0}};
          // Second half dark, then ready for the next pulse
          if (o_lamp)
            o_lamp <= 1'b0;
          else
            busy_reg <= 1'b0;
        end
        else
          cnt_reg <= cnt_reg + 27'd1;
      end
      else if (i_pulse_sync && !prev_reg)
      begin
        busy_reg <= 1'b1;
        o_lamp <= 1'b1;
        cnt_reg <= {`CSI_CNT_W{1'b0}};
      end
    end
  end

endmodule

/* File: verif/csi_field_src.sv */
`timescale 1ns/100ps
// ********
// Field pulse source
// ********
module csi_field_src (
  input wire i_ref_clk,
  input wire [7:0] i_en,
  input wire [7:0] i_gap,
  output reg [7:0] o_pulse = 8'h00
);
  reg [7:0] cnt_reg = 8'h00;
  // Six-cycle pulses, period gap+1; launched just after the edge
  always @(posedge i_ref_clk)
  begin
    cnt_reg <= (cnt_reg >= i_gap) ? 8'h00 : cnt_reg + 8'h01;
    o_pulse <= #1 i_en & {8{cnt_reg < 8'h06}};
  end
endmodule

/* File: verif/csi_status_lamps_checker.sv */
`timescale 1ns/100ps
// ********
// Lamp checks
// ********
module csi_status_lamps_checker (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_module_fail,
  input wire i_net_tx_ok,
  input wire [7:0] i_chan_pulse,
  input wire [7:0] i_chan_function_input,
  input wire o_run_lamp,
  input wire o_link_lamp,
  input wire o_fault_lamp,
  input wire [7:0] o_chan_pulse_lamp,
  input wire [7:0] o_chan_function_lamp
);
  // Enabled cycles since i_ce was last low, saturating; history checks wait
  reg [3:0] ce_run_reg = 4'h0;
  always @(posedge i_ref_clk)
    ce_run_reg <= !i_ce ? 4'h0 : ce_run_reg + {3'h0, ce_run_reg != 4'hf};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst || ce_run_reg != 4'hf);
  // Sixteen healthy cycles so the blink window is free of fail or reset
  sequence s_ok; !(i_module_fail || i_rst) [*8] ##1 !(i_module_fail || i_rst) [*8]; endsequence
  sequence s_idle; !o_chan_pulse_lamp[0] [*8]; endsequence
  sequence s_flash; o_chan_pulse_lamp[0] [*4] ##1 !o_chan_pulse_lamp[0] [*4]; endsequence
  chk_link_follow: assert property (o_link_lamp == $past(i_net_tx_ok, 3))
    else $error("link lamp wrong");
  chk_fault_follow: assert property (o_fault_lamp == $past(i_module_fail, 3))
    else $error("fault lamp wrong");
  chk_func_follow: assert property (o_chan_function_lamp == $past(i_chan_function_input, 3))
    else $error("function lamp wrong");
  chk_run_steady: assert property ($past(i_module_fail, 3) |-> o_run_lamp)
    else $error("run lamp not steady");
  chk_run_blink: assert property (s_ok ##0 $changed(o_run_lamp) |->
    $past(o_run_lamp, 1) == $past(o_run_lamp, 8) && $past(o_run_lamp, 8) != $past(o_run_lamp, 9))
    else $error("run blink period");
  chk_pulse_cause: assert property ((o_chan_pulse_lamp & ~$past(o_chan_pulse_lamp) &
    ~($past(i_chan_pulse, 3) | $past(i_chan_pulse, 4))) == 8'h00) else $error("stray flash");
  chk_pulse_fire: assert property (s_idle ##0 $rose(i_chan_pulse[0]) |->
    ##[2:5] $rose(o_chan_pulse_lamp[0])) else $error("pulse missed");
  chk_flash_width: assert property ($rose(o_chan_pulse_lamp[0]) |-> s_flash)
    else $error("flash width");
  chk_freeze_hold: assert property (disable iff (i_rst) !i_ce |=>
    $stable({o_run_lamp, o_link_lamp, o_fault_lamp, o_chan_pulse_lamp, o_chan_function_lamp}))
    else $error("lamps moved while frozen");
endmodule
bind csi_status_lamps csi_status_lamps_checker u_chk (.*);

/* File: verif/tb_csi_status_lamps.sv */
`timescale 1ns/100ps
module tb_csi_status_lamps;
  reg i_ref_clk = 0, i_rst = 1, ce = 1, fail = 0, ok = 0;
  reg [7:0] fin = 8'h00, en = 8'h00, gap = 8'h28, seen, dark;
  wire [7:0] pulse, plamp, flamp;
  wire run, link, flt;
  integer fails = 0, checks = 0, cyc = 0, n, k;
  reg p, q;
  csi_field_src u_src (.i_ref_clk(i_ref_clk), .i_en(en), .i_gap(gap), .o_pulse(pulse));
  // Short counts keep the run brief
  csi_status_lamps #(.RUN_HALF_CYC(27'd8), .STRETCH_CYC(27'd4)) u_dut (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_ce(ce), .i_module_fail(fail), .i_net_tx_ok(ok), .i_chan_pulse(pulse),
    .i_chan_function_input(fin), .o_run_lamp(run), .o_link_lamp(link), .o_fault_lamp(flt),
    .o_chan_pulse_lamp(plamp), .o_chan_function_lamp(flamp));
  initial forever #2 i_ref_clk = ~i_ref_clk;
  // Inputs move 1 ns after the edge, clear of sampling
  task step(input integer c);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask
  task cmp(input [7:0] got, input [7:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Level lamps over all link and fail combinations
  task t_level;
    for (n = 0; n < 4; n = n + 1)
    begin
      ok = n[0];
      fail = n[1];
      fin = 8'h81 << n[1:0];
      step(4);
      cmp(link, ok);
      cmp(flt, fail);
      cmp(flamp, fin);
      if (fail) cmp(run, 1'b1);
    end
    fail = 0;
    $display("level done");
  endtask
  // Healthy blink: eight changes in 64 cycles
  task t_blink;
    step(20);
    k = 0;
    repeat (64)
    begin
      p = run;
      step(1);
      if (run !== p) k = k + 1;
    end
    cmp(k[7:0], 8'h08);
    $display("blink done");
  endtask
  // Slow then fast pulses on the outer channels only
  task t_pulse;
    for (n = 0; n < 2; n = n + 1)
    begin
      gap = n ? 8'h06 : 8'h28;
      en = 8'h81;
      seen = 8'h00;
      dark = 8'h00;
      repeat (100)
      begin
        step(1);
        seen = seen | plamp;
        dark = dark | (seen & ~plamp);
      end
      cmp(seen, 8'h81);
      cmp(dark, 8'h81);
      en = 8'h00;
      step(30);
      cmp(plamp, 8'h00);
    end
    $display("pulse done");
  endtask
  // Clock enable low holds every lamp, then the lamps catch up
  task t_freeze;
    p = run;
    q = link;
    seen = flamp;
    ce = 0;
    ok = ~ok;
    fin = ~fin;
    en = 8'h01;
    step(12);
    cmp(run, p);
    cmp(link, q);
    cmp(flamp, seen);
    cmp(plamp, 8'h00);
    ce = 1;
    step(4);
    cmp(link, ok);
    cmp(flamp, fin);
    en = 8'h00;
    step(24);
    $display("freeze done");
  endtask
  // Mid-run reset beats a failure; inputs idle well before release
  task t_reset;
    fail = 1;
    ok = 1;
    fin = 8'hff;
    step(4);
    cmp(flt, 1'b1);
    i_rst = 1;
    step(2);
    cmp({run, link, flt}, 8'h00);
    cmp(flamp | plamp, 8'h00);
    fail = 0;
    ok = 0;
    fin = 8'h00;
    step(4);
    i_rst = 0;
    $display("reset done");
  endtask
  always @(posedge i_ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      fails = fails + 1;
      summarize;
    end
  end
  initial
  begin
    step(16);
    cmp({run, link, flt}, 8'h00);
    i_rst = 0;
    t_level;
    t_blink;
    t_pulse;
    t_freeze;
    t_reset;
    t_blink;
    summarize;
  end
endmodule
